// ==== logic/tpte_defines.svh ====
// Purpose: constants for the third-party transfer engine
// Assumes: one clock, synchronous reset
// Notes: message codes and status codes are local choices
`ifndef TPTE_DEFINES_SVH
`define TPTE_DEFINES_SVH
`define TPTE_TYPE_W 2
`define TPTE_TYPE_BLOCK 2'h0
`define TPTE_TYPE_ND 2'h1
`define TPTE_TYPE_EV 2'h2
`define TPTE_STAT_OK 2'h0
`define TPTE_STAT_REJ 2'h1
`define TPTE_SUBSET_ALL 4'h7
`define TPTE_SUBSET_BLOCK 4'h1
`define TPTE_DIMS 4
`endif

// ==== logic/tpte_pkg.sv ====
// Purpose: types for the third-party transfer engine
// Assumes: nothing
// Notes: states of the request sequencer
package tpte_pkg;
    typedef enum logic [2:0] {
        TPTE_IDLE,
        TPTE_READ,
        TPTE_WAIT,
        TPTE_WRITE,
        TPTE_RESP
    } tpte_state_t;
endpackage : tpte_pkg

// ==== logic/tpte_loop_counter.sv ====
// Purpose: four-level nested loop counter with address stepping
// Assumes: counts of zero are treated as one
// Notes: step advances the innermost level, carries outward
`timescale 1ns/1ps
`include "tpte_defines.svh"
module tpte_loop_counter #(
    parameter int CW = 16,
    parameter int AW = 32
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic load_in,
    input wire logic step_in,
    input wire logic [4*CW-1:0] cnt_in,
    input wire logic [4*AW-1:0] src_stride_in,
    input wire logic [4*AW-1:0] dst_stride_in,
    input wire logic [AW-1:0] src_base_in,
    input wire logic [AW-1:0] dst_base_in,
    output logic [AW-1:0] src_addr_out,
    output logic [AW-1:0] dst_addr_out,
    output logic [3:0] wrap_out,
    output logic [3:0] wrap_now_out,
    output logic last_out
);
    if (CW < 1 || AW < 1) begin : g_bad_params
        $error("tpte_loop_counter: unusable parameters");
    end

    logic [CW-1:0] idx [4];
    logic [CW-1:0] next_idx [4];
    logic [AW-1:0] next_src, next_dst;
    logic [3:0] wrap;

    function automatic logic [CW-1:0] lim(input logic [CW-1:0] c);
        lim = (c == '0) ? '0 : c - 1'b1;
    endfunction : lim

    function automatic logic [AW-1:0] offs(input logic [4*AW-1:0] st);
        logic [AW-1:0] s;
        s = '0;
        for (int d = 0; d < 4; d++) begin
            s = AW'(s + AW'(st[d*AW +: AW] * next_idx[d]));
        end
        offs = s;
    endfunction : offs

    // Carry chain of the step taken in this cycle
    always_comb begin
        logic carry;
        carry = step_in;
        for (int d = 0; d < 4; d++) begin
            wrap[d] = carry && (idx[d] == lim(cnt_in[d*CW +: CW]));
            carry = wrap[d];
        end
    end

    assign wrap_now_out = wrap;

    always_comb begin
        logic carry;
        carry = step_in;
        for (int d = 0; d < 4; d++) begin
            if (load_in) begin
                next_idx[d] = '0;
            end else if (carry) begin
                next_idx[d] = wrap[d] ? '0 : idx[d] + 1'b1;
            end else begin
                next_idx[d] = idx[d];
            end
            carry = wrap[d];
        end
        next_src = AW'(src_base_in + offs(src_stride_in));
        next_dst = AW'(dst_base_in + offs(dst_stride_in));
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            for (int d = 0; d < 4; d++) idx[d] <= '0;
            src_addr_out <= '0;
            dst_addr_out <= '0;
            wrap_out <= '0;
            last_out <= 1'b0;
        end else if (ce_in) begin
            for (int d = 0; d < 4; d++) idx[d] <= next_idx[d];
            src_addr_out <= next_src;
            dst_addr_out <= next_dst;
            wrap_out <= wrap;
            last_out <= (&wrap) && !load_in;
        end
    end
endmodule : tpte_loop_counter

// ==== logic/tpte_engine.sv ====
// Purpose: third-party transfer engine top, executes transfer requests
// Assumes: link and memory ports synchronous to clk_sys_in
// Notes: one request in flight; data passes through one holding word
//
// Behaviour
// - Requests arrive only over the packet streaming link request port
// - Each request of a supported type copies source reads to destination writes in four nested loops
// - Supported message types are a fixed per-instance subset mask
// - Finished request returns a response tagged for the originating controller
// - Events emitted at completion points selected in the request
// - Block-copy variant accepts only block copy message type
// - Engine only reads source and writes sink, never owns data
`timescale 1ns/1ps
`include "tpte_defines.svh"
module tpte_engine
    import tpte_pkg::*;
#(
    parameter int DW = 32,
    parameter int AW = 32,
    parameter int CW = 16,
    parameter int TW = 8,
    parameter logic [3:0] SUBSET = `TPTE_SUBSET_ALL
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic req_valid_in,
    output logic req_ready_out,
    input wire logic [`TPTE_TYPE_W-1:0] req_type_in,
    input wire logic [TW-1:0] req_tag_in,
    input wire logic [3:0] req_event_sel_in,
    input wire logic [4*CW-1:0] req_cnt_in,
    input wire logic [AW-1:0] req_src_in,
    input wire logic [AW-1:0] req_dst_in,
    input wire logic [4*AW-1:0] req_src_stride_in,
    input wire logic [4*AW-1:0] req_dst_stride_in,
    output logic rsp_valid_out,
    input wire logic rsp_ready_in,
    output logic [TW-1:0] rsp_tag_out,
    output logic [1:0] rsp_status_out,
    output logic rd_req_out,
    output logic [AW-1:0] rd_addr_out,
    input wire logic rd_ack_in,
    input wire logic [DW-1:0] rd_data_in,
    output logic wr_req_out,
    output logic [AW-1:0] wr_addr_out,
    output logic [DW-1:0] wr_data_out,
    input wire logic wr_ack_in,
    output logic event_out,
    output logic [TW-1:0] event_tag_out
);
    if (SUBSET == 4'h0 || DW < 8 || CW < 1 || TW < 1) begin : g_bad_params
        $error("tpte_engine: unusable parameters");
    end

    ////////////////////////////////////////////////////////////////////
    tpte_state_t state, next_state;
    logic [TW-1:0] tag, next_tag;
    logic [3:0] ev_sel, next_ev_sel;
    logic [4*CW-1:0] cnt, next_cnt;
    logic [AW-1:0] src, next_src, dst, next_dst;
    logic [4*AW-1:0] sst, next_sst, dstr, next_dstr;
    logic [DW-1:0] data, next_data;
    logic next_req_ready, next_rsp_valid, next_rd_req, next_wr_req, next_event;
    logic [1:0] next_status;
    logic [AW-1:0] lc_src, lc_dst;
    logic [3:0] lc_wrap_now;
    logic lc_last, lc_load, lc_step;

    function automatic logic type_ok(input logic [`TPTE_TYPE_W-1:0] t);
        type_ok = SUBSET[t];
    endfunction : type_ok

    tpte_loop_counter #(.CW(CW), .AW(AW)) u_loop (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .load_in(lc_load),
        .step_in(lc_step),
        .cnt_in(cnt),
        .src_stride_in(sst),
        .dst_stride_in(dstr),
        .src_base_in(next_src),
        .dst_base_in(next_dst),
        .src_addr_out(lc_src),
        .dst_addr_out(lc_dst),
        .wrap_out(),
        .wrap_now_out(lc_wrap_now),
        .last_out(lc_last)
    );

    // Bases fed from next values so the first read address is ready in time
    assign lc_load = (state == TPTE_IDLE) && req_valid_in && req_ready_out;
    assign lc_step = (state == TPTE_WRITE) && wr_ack_in;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        next_state = state;
        next_tag = tag;
        next_ev_sel = ev_sel;
        next_cnt = cnt;
        next_src = src;
        next_dst = dst;
        next_sst = sst;
        next_dstr = dstr;
        next_data = data;
        next_req_ready = 1'b0;
        next_rsp_valid = rsp_valid_out;
        next_status = rsp_status_out;
        next_rd_req = 1'b0;
        next_wr_req = 1'b0;
        next_event = 1'b0;
        unique case (state)
            TPTE_IDLE: begin
                next_req_ready = 1'b1;
                if (req_valid_in && req_ready_out) begin
                    next_req_ready = 1'b0;
                    next_tag = req_tag_in;
                    next_ev_sel = req_event_sel_in;
                    next_cnt = req_cnt_in;
                    next_src = req_src_in;
                    next_dst = req_dst_in;
                    next_sst = req_src_stride_in;
                    next_dstr = req_dst_stride_in;
                    if (type_ok(req_type_in)) begin
                        next_state = TPTE_READ;
                    end else begin
                        next_status = `TPTE_STAT_REJ;
                        next_rsp_valid = 1'b1;
                        next_state = TPTE_RESP;
                    end
                end
            end
            TPTE_READ: begin
                next_rd_req = 1'b1;
                next_state = TPTE_WAIT;
            end
            TPTE_WAIT: begin
                next_rd_req = !rd_ack_in;
                if (rd_ack_in) begin
                    next_data = rd_data_in;
                    next_wr_req = 1'b1;
                    next_state = TPTE_WRITE;
                end
            end
            TPTE_WRITE: begin
                next_wr_req = !wr_ack_in;
                if (wr_ack_in) begin
                    next_event = |(ev_sel & lc_wrap_now);
                    if (&lc_wrap_now) begin
                        next_status = `TPTE_STAT_OK;
                        next_rsp_valid = 1'b1;
                        next_state = TPTE_RESP;
                    end else begin
                        next_state = TPTE_READ;
                    end
                end
            end
            TPTE_RESP: begin
                if (rsp_ready_in) begin
                    next_rsp_valid = 1'b0;
                    next_req_ready = 1'b1;
                    next_state = TPTE_IDLE;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state <= TPTE_IDLE;
            tag <= '0;
            ev_sel <= '0;
            cnt <= '0;
            src <= '0;
            dst <= '0;
            sst <= '0;
            dstr <= '0;
            data <= '0;
            req_ready_out <= 1'b0;
            rsp_valid_out <= 1'b0;
            rsp_tag_out <= '0;
            rsp_status_out <= `TPTE_STAT_OK;
            rd_req_out <= 1'b0;
            rd_addr_out <= '0;
            wr_req_out <= 1'b0;
            wr_addr_out <= '0;
            wr_data_out <= '0;
            event_out <= 1'b0;
            event_tag_out <= '0;
        end else if (ce_in) begin
            state <= next_state;
            tag <= next_tag;
            ev_sel <= next_ev_sel;
            cnt <= next_cnt;
            src <= next_src;
            dst <= next_dst;
            sst <= next_sst;
            dstr <= next_dstr;
            data <= next_data;
            req_ready_out <= next_req_ready;
            rsp_valid_out <= next_rsp_valid;
            rsp_tag_out <= next_tag;
            rsp_status_out <= next_status;
            rd_req_out <= next_rd_req;
            rd_addr_out <= lc_src;
            wr_req_out <= next_wr_req;
            wr_addr_out <= lc_dst;
            wr_data_out <= next_data;
            event_out <= next_event;
            event_tag_out <= next_tag;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_write_done;
        wr_req_out && wr_ack_in && ce_in;
    endsequence

    AST_ONE_SOURCE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (state != TPTE_IDLE) |-> !req_ready_out)
        else $error("request accepted while busy");
    AST_REJECT_NO_MOVE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (rsp_valid_out && rsp_status_out == `TPTE_STAT_REJ) |-> (!rd_req_out && !wr_req_out))
        else $error("rejected request moved data");
    AST_SUBSET: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (req_valid_in && req_ready_out && ce_in && !type_ok(req_type_in))
        |=> (rsp_valid_out && rsp_status_out == `TPTE_STAT_REJ))
        else $error("unsupported type not rejected");
    AST_READ_BEFORE_WRITE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $rose(wr_req_out) |-> $past(state) == TPTE_WAIT)
        else $error("write without preceding read");
    AST_RSP_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (rsp_valid_out && !rsp_ready_in) |=> (rsp_valid_out && $stable(rsp_tag_out)))
        else $error("response dropped before taken");
    AST_RD_WR_EXCL: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !(rd_req_out && wr_req_out))
        else $error("read and write overlap");
    AST_NEXT_READ: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        s_write_done |=> (state == TPTE_READ || state == TPTE_RESP))
        else $error("write completion not followed");
    AST_EVENT_PULSE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        event_out |-> ($past(state) == TPTE_WRITE && $past(ev_sel) != 4'h0))
        else $error("event without selected point");
    AST_LAST_RESP: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        lc_last |-> (state == TPTE_RESP && rsp_status_out == `TPTE_STAT_OK))
        else $error("final element not answered");
endmodule : tpte_engine

// ==== tb/tpte_mem_model.sv ====
// Purpose: source and sink memory beside the transfer engine
// Assumes: read data is a fixed function of the address
// Notes: slow mode delays acks pseudo-randomly
`timescale 1ns/1ps
module tpte_mem_model #(
    parameter int DW = 32,
    parameter int AW = 32
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic slow_in,
    input wire logic rd_req_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic rd_ack_out,
    output logic [DW-1:0] rd_data_out,
    input wire logic wr_req_in,
    output logic wr_ack_out
);
    ////////////////////////////////////////////////////////////
    logic [15:0] lfsr;
    always @(posedge clk_sys_in) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        rd_ack_out <= 1'b0;
        wr_ack_out <= 1'b0;
        // Stale data toggles so it never looks valid
        rd_data_out <= ~rd_data_out;
        if (rst_in) begin
            lfsr <= 16'hACE1;
            rd_data_out <= '0;
        end else begin
            if (rd_req_in && !rd_ack_out && (!slow_in || lfsr[0])) begin
                rd_ack_out <= 1'b1;
                rd_data_out <= DW'(rd_addr_in ^ AW'(32'h5A5A_0000));
            end
            if (wr_req_in && !wr_ack_out && (!slow_in || lfsr[1])) begin
                wr_ack_out <= 1'b1;
            end
        end
    end
endmodule : tpte_mem_model

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the transfer engine
// Assumes: bench acts as the requesting controller
// Notes: memory model answers reads and writes
`timescale 1ns/1ps
`include "tpte_defines.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %0h seen %0h", n, e, g); end end
module testbench;
    localparam logic [3:0] SUB = `TPTE_SUBSET_ALL;
    logic clk_sys_in = 0, rst_in = 1, req_valid_in = 0, rsp_ready_in = 0, slow = 0;
    logic [1:0] req_type_in = '0, rsp_status_out;
    logic [7:0] req_tag_in = '0, rsp_tag_out, event_tag_out;
    logic [3:0] req_event_sel_in = '0;
    logic [63:0] req_cnt_in = '0;
    logic [31:0] req_src_in = '0, req_dst_in = '0, rd_addr_out, rd_data_in;
    logic [31:0] wr_addr_out, wr_data_out;
    logic [127:0] req_src_stride_in = '0, req_dst_stride_in = '0;
    logic req_ready_out, rsp_valid_out, rd_req_out, rd_ack_in, wr_req_out, wr_ack_in;
    logic event_out;
    logic [63:0] expq[$];
    logic [63:0] got;
    logic [31:0] lfsr = 32'hdf6b;
    int miscompares = 0, n_checks = 0, n_rd = 0, n_ev = 0;
    ////////////////////////////////////////////////////////////
    initial forever #5 clk_sys_in = ~clk_sys_in;
    tpte_engine #(.SUBSET(SUB)) dut (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(1'b1),
        .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
        .req_type_in(req_type_in), .req_tag_in(req_tag_in),
        .req_event_sel_in(req_event_sel_in), .req_cnt_in(req_cnt_in),
        .req_src_in(req_src_in), .req_dst_in(req_dst_in),
        .req_src_stride_in(req_src_stride_in), .req_dst_stride_in(req_dst_stride_in),
        .rsp_valid_out(rsp_valid_out), .rsp_ready_in(rsp_ready_in),
        .rsp_tag_out(rsp_tag_out), .rsp_status_out(rsp_status_out),
        .rd_req_out(rd_req_out), .rd_addr_out(rd_addr_out), .rd_ack_in(rd_ack_in),
        .rd_data_in(rd_data_in), .wr_req_out(wr_req_out), .wr_addr_out(wr_addr_out),
        .wr_data_out(wr_data_out), .wr_ack_in(wr_ack_in),
        .event_out(event_out), .event_tag_out(event_tag_out));
    tpte_mem_model mem (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .slow_in(slow),
        .rd_req_in(rd_req_out), .rd_addr_in(rd_addr_out), .rd_ack_out(rd_ack_in),
        .rd_data_out(rd_data_in), .wr_req_in(wr_req_out), .wr_ack_out(wr_ack_in));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task print_verdict();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : print_verdict
    task timed_out();
        miscompares++;
        print_verdict();
    endtask : timed_out
    // Transfers seen at negedge are sampled by the engine next edge
    always @(negedge clk_sys_in) begin
        if (rd_req_out && rd_ack_in) n_rd++;
        if (event_out) begin
            n_ev++;
            `CHK("event tag", req_tag_in, event_tag_out)
        end
        if (wr_req_out && wr_ack_in) begin
            got = expq.size() ? expq.pop_front() : ~{wr_addr_out, wr_data_out};
            `CHK("write", got, {wr_addr_out, wr_data_out})
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic do_req(input logic [1:0] ty, input logic [63:0] cnt);
        int c[4];
        int k, ne, r, t;
        logic [31:0] src, dst, sa, da;
        logic [127:0] ss, ds;
        logic [3:0] sel;
        logic [7:0] tag;
        src = rnd();
        dst = rnd();
        ss = {rnd(), rnd(), rnd(), rnd()} & {4{32'h0000_03FC}};
        ds = {rnd(), rnd(), rnd(), rnd()} & {4{32'h0000_03FC}};
        sel = 4'(rnd());
        tag = 8'(rnd());
        for (int d = 0; d < 4; d++) c[d] = (cnt[16*d +: 16] == 0) ? 1 : int'(cnt[16*d +: 16]);
        ne = 0;
        k = 1;
        for (int d = 3; d >= 0; d--) begin
            // One pulse per step: lowest selected loop sets the count
            if (sel[d]) ne = k;
            k *= c[d];
        end
        if (!SUB[ty]) begin
            k = 0;
            ne = 0;
        end
        for (int a = 0; a < k; a++) begin
            sa = src;
            da = dst;
            r = a;
            for (int d = 0; d < 4; d++) begin
                sa += 32'(r % c[d]) * ss[32*d +: 32];
                da += 32'(r % c[d]) * ds[32*d +: 32];
                r /= c[d];
            end
            expq.push_back({da, sa ^ 32'h5A5A_0000});
        end
        @(posedge clk_sys_in);
        n_rd = 0;
        n_ev = 0;
        req_valid_in <= 1'b1;
        req_type_in <= ty;
        req_tag_in <= tag;
        req_event_sel_in <= sel;
        req_cnt_in <= cnt;
        req_src_in <= src;
        req_dst_in <= dst;
        req_src_stride_in <= ss;
        req_dst_stride_in <= ds;
        slow <= lfsr[3];
        @(negedge clk_sys_in);
        for (t = 0; t < 3000 && !req_ready_out; t++) @(negedge clk_sys_in);
        if (t == 3000) timed_out();
        @(posedge clk_sys_in);
        req_valid_in <= 1'b0;
        @(negedge clk_sys_in);
        for (t = 0; t < 3000 && !rsp_valid_out; t++) @(negedge clk_sys_in);
        if (t == 3000) timed_out();
        `CHK("rsp tag", tag, rsp_tag_out)
        `CHK("rsp status", SUB[ty] ? `TPTE_STAT_OK : `TPTE_STAT_REJ,
            rsp_status_out)
        repeat (lfsr[1:0]) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        `CHK("rsp held", 1'b1, rsp_valid_out)
        @(posedge clk_sys_in);
        rsp_ready_in <= 1'b1;
        @(posedge clk_sys_in);
        rsp_ready_in <= 1'b0;
        repeat (2) @(posedge clk_sys_in);
        `CHK("reads", k, n_rd)
        `CHK("writes left", 0, expq.size())
        `CHK("events", ne, n_ev)
    endtask : do_req
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (15) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        `CHK("reset outputs", 5'h00, {req_ready_out, rsp_valid_out, rd_req_out, wr_req_out, event_out})
        @(posedge clk_sys_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            if (i[0])
                do_req(`TPTE_TYPE_ND, {16'(rnd() % 3 + 1), 16'(rnd() % 3 + 1),
                    16'(rnd() % 3 + 1), 16'(rnd() % 4 + 1)});
            else
                do_req(`TPTE_TYPE_BLOCK, {48'h0001_0001_0001, 16'(rnd() % 6 + 1)});
        end
        do_req(`TPTE_TYPE_ND, 64'h0);
        do_req(2'h3, 64'h0001_0001_0002_0003);
        do_req(`TPTE_TYPE_EV, 64'h0001_0001_0002_0002);
        do_req(`TPTE_TYPE_BLOCK, 64'h0001_0001_0001_0008);
        print_verdict();
    end
endmodule : testbench
